// ==== verilog/pwh_pkg.sv ====
// Constants, field layouts and types for the parallel word handshake sequencer.
// Assumes a single 200 MHz system clock and a plain synchronous register port.
//
// Contract
// - Read command raises read select and ready.
// - Drop read ready within 1 usec of demand.
// - Clear buffer, re-raise read ready, demand low.
// - Record end gives device+channel end; file adds exception.
// - Terminate read only after last byte sent.
// - Channel stop raises count zero with read ready.
// - Demand after count zero: channel end, discard, repeat.
// - Interrupt, timeout or reset drop all lines.
// - Read timeout starts at command, restarts on demand.
// - Write raises select, fetches word, then ready.
// - Write demand drops ready, restarts timeout, fetches.
// - Output parity makes ones count odd.
// - Write ready only with stable data, demand low.
// - Early write end flags unit check, incomplete.
// - Write stop finishes word, then count zero.
// - Demand after write count zero sends zero words.
// - Word is 16 to 48 bits, bytewise.
// - Interrupt sets attention, plus ends inside operations.
package pwh_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS  = 5;
  localparam int RDY_DROP_NS    = 1000;
  localparam int RDY_DROP_CYC   = RDY_DROP_NS / CLK_PERIOD_NS;
  localparam int WORD_BITS_DEF  = 16;
  localparam int WORD_BITS_MAX  = 48;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] ADDR_CMD   = 8'h00;
  localparam logic [7:0] ADDR_STAT  = 8'h04;
  localparam int         CMD_STOP   = 3;
  localparam logic [2:0] CMD_IDLE   = 3'h0;
  localparam logic [2:0] CMD_READ   = 3'h1;
  localparam logic [2:0] CMD_READ_T = 3'h2;
  localparam logic [2:0] CMD_WRITE  = 3'h3;
  localparam logic [2:0] CMD_WRIT_T = 3'h4;

  // Status bit positions; bit 0 is live, bits 8..1 are sticky.
  localparam int ST_BUSY   = 0;
  localparam int ST_CE     = 1;
  localparam int ST_DE     = 2;
  localparam int ST_UE     = 3;
  localparam int ST_UC     = 4;
  localparam int ST_ATTN   = 5;
  localparam int ST_INCOMP = 6;
  localparam int ST_TMO    = 7;
  localparam int ST_PAR    = 8;
  localparam logic [8:1] STAT_RST = 8'h00;

  typedef enum logic [2:0] {
    S_IDLE,
    S_RD_WAIT,
    S_RD_SEND,
    S_WR_FILL,
    S_WR_WAIT
  } pwh_state_type;

endpackage

// ==== verilog/pwh_sync.sv ====
// Two-stage synchroniser for a group of slow link inputs.
// Assumes each input is held far longer than two clock periods.
`timescale 1ns/1ps
module pwh_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      o_sync <= '0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule // pwh_sync

// ==== verilog/pwh_word_adapter.sv ====
// Sequencer for a half-duplex demand/response parallel word link.
// Assumes a channel side byte stream with valid/ready and a plain register port.
`timescale 1ns/1ps
module pwh_word_adapter
  import pwh_pkg::*;
#(
  parameter int          WORD_BITS   = WORD_BITS_DEF,
  parameter logic [31:0] TIMEOUT_CYC = 32'd2000000
) (
  input  wire logic                 I_CLK_SYS,
  input  wire logic                 I_SYS_RST,
  input  wire logic [7:0]           I_ADDR,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic                 I_WR,
  input  wire logic                 I_RD,
  output logic      [31:0]          O_RDATA,
  input  wire logic [7:0]           I_CH_WDATA,
  input  wire logic                 I_CH_WVALID,
  output logic                      O_CH_WREADY,
  output logic      [7:0]           O_CH_RDATA,
  output logic                      O_CH_RVALID,
  input  wire logic                 I_CH_RREADY,
  output logic                      O_READ_SEL,
  output logic                      O_WRITE_SEL,
  output logic                      O_READ_RDY,
  output logic                      O_WRITE_RDY,
  output logic                      O_COUNT_ZERO,
  output logic      [WORD_BITS-1:0] O_DATA_OUT,
  output logic                      O_PARITY_OUT,
  input  wire logic                 I_DEMAND,
  input  wire logic                 I_END_RECORD,
  input  wire logic                 I_END_FILE,
  input  wire logic                 I_INTERRUPT,
  input  wire logic [WORD_BITS-1:0] I_DATA_IN,
  input  wire logic                 I_PARITY_IN
);

  localparam int NB = WORD_BITS / 8;
  localparam logic [2:0] LAST_IDX = 3'(NB - 1);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [WORD_BITS+4:0] sync_w;
  logic                 dem_s;
  logic                 eor_s;
  logic                 eof_s;
  logic                 int_s;
  logic                 par_s;
  logic [WORD_BITS-1:0] din_s;

  // Data is held for the whole demand pulse, so it settles before demand is seen.
  pwh_sync #(.WIDTH(WORD_BITS + 5)) u_sync (
    .i_clk   (I_CLK_SYS),
    .i_rst   (I_SYS_RST),
    .i_async ({I_INTERRUPT, I_END_FILE, I_END_RECORD, I_DEMAND, I_PARITY_IN, I_DATA_IN}),
    .o_sync  (sync_w)
  );

  assign {int_s, eof_s, eor_s, dem_s, par_s, din_s} = sync_w;

  // ****************************************************************
  // State
  // ****************************************************************
  pwh_state_type        state_q, state_d;
  logic                 rsel_q, rsel_d, wsel_q, wsel_d;
  logic                 rrdy_q, rrdy_d, wrdy_q, wrdy_d;
  logic                 cz_q, cz_d, par_q, par_d;
  logic [WORD_BITS-1:0] dout_q, dout_d, buf_q, buf_d;
  logic [2:0]           idx_q, idx_d, cmd_q, cmd_d;
  logic                 to_en_q, to_en_d, stop_q, stop_d;
  logic                 endp_q, endp_d, uep_q, uep_d;
  logic                 wpend_q, wpend_d, int_d1_q, int_d1_d;
  logic [31:0]          tmr_q, tmr_d, rdata_q, rdata_d;
  logic                 chrv_q, chrv_d, chwr_q, chwr_d;
  logic [7:0]           chrd_q, chrd_d;
  logic [8:1]           stat_q, stat_d, set_v;
  logic                 busy, int_rise, tmo, kill, done, wacc;
  logic [WORD_BITS-1:0] wbuf;

  always_comb begin
    state_d  = state_q;
    rsel_d   = rsel_q;
    wsel_d   = wsel_q;
    rrdy_d   = rrdy_q;
    wrdy_d   = wrdy_q;
    cz_d     = cz_q;
    par_d    = par_q;
    dout_d   = dout_q;
    buf_d    = buf_q;
    idx_d    = idx_q;
    cmd_d    = cmd_q;
    to_en_d  = to_en_q;
    stop_d   = stop_q;
    endp_d   = endp_q;
    uep_d    = uep_q;
    wpend_d  = wpend_q;
    chrv_d   = chrv_q;
    chrd_d   = chrd_q;
    chwr_d   = chwr_q;
    int_d1_d = int_s;
    set_v    = '0;
    done     = 1'b0;
    wbuf     = '0;
    busy     = state_q != S_IDLE;
    int_rise = int_s & ~int_d1_q;
    tmo      = to_en_q && (tmr_q == TIMEOUT_CYC - 32'd1);
    kill     = busy && (int_rise || tmo);
    wacc     = chwr_q && I_CH_WVALID;
    // The timeout only runs while a word waits on the far side.
    tmr_d    = (state_q == S_RD_WAIT || state_q == S_WR_WAIT) ? tmr_q + 32'd1 : 32'd0;

    // ****************************************************************
    // Sequencer
    // ****************************************************************
    case (state_q)
      S_IDLE: begin
        if (I_WR && I_ADDR == ADDR_CMD) begin
          cmd_d = I_WDATA[2:0];
          if (I_WDATA[2:0] == CMD_READ || I_WDATA[2:0] == CMD_READ_T) begin
            rsel_d  = 1'b1;
            rrdy_d  = 1'b1;
            to_en_d = I_WDATA[2:0] == CMD_READ_T;
            buf_d   = '0;
            state_d = S_RD_WAIT;
          end else if (I_WDATA[2:0] == CMD_WRITE || I_WDATA[2:0] == CMD_WRIT_T) begin
            wsel_d  = 1'b1;
            chwr_d  = 1'b1;
            to_en_d = I_WDATA[2:0] == CMD_WRIT_T;
            idx_d   = '0;
            wpend_d = 1'b0;
            state_d = S_WR_FILL;
          end else begin
            cmd_d = CMD_IDLE;
          end
        end
      end
      S_RD_WAIT: begin
        if (eor_s || eof_s) begin
          done          = 1'b1;
          set_v[ST_DE]  = 1'b1;
          set_v[ST_CE]  = 1'b1;
          set_v[ST_UE]  = eof_s;
        end else if (rrdy_q && dem_s) begin
          rrdy_d = 1'b0;
          tmr_d  = '0;
          if (cz_q) begin
            set_v[ST_CE] = 1'b1;
          end else begin
            buf_d         = din_s;
            set_v[ST_PAR] = ~(^{din_s, par_s});
            idx_d         = '0;
            state_d       = S_RD_SEND;
          end
        end else if (!dem_s && (stop_q || !rrdy_q)) begin
          rrdy_d = 1'b1;
          cz_d   = cz_q | stop_q;
        end
      end
      S_RD_SEND: begin
        // An end signal seen while bytes drain waits for the last byte.
        if (eor_s || eof_s) begin
          endp_d = 1'b1;
          uep_d  = uep_q | eof_s;
        end
        if (!chrv_q) begin
          chrv_d = 1'b1;
          chrd_d = buf_q[WORD_BITS-1 -: 8];
        end else if (I_CH_RREADY) begin
          chrv_d = 1'b0;
          buf_d  = buf_q << 8;
          idx_d  = idx_q + 3'd1;
          if (idx_q == LAST_IDX) begin
            buf_d = '0;
            if (endp_q || eor_s || eof_s) begin
              done         = 1'b1;
              set_v[ST_DE] = 1'b1;
              set_v[ST_CE] = 1'b1;
              set_v[ST_UE] = uep_q | eof_s;
            end else begin
              state_d = S_RD_WAIT;
            end
          end
        end
      end
      S_WR_FILL: begin
        if (eor_s || eof_s) begin
          done             = 1'b1;
          set_v[ST_DE]     = 1'b1;
          set_v[ST_CE]     = 1'b1;
          set_v[ST_UE]     = eof_s;
          set_v[ST_UC]     = !cz_q && (wpend_q || idx_q != 3'd0);
          set_v[ST_INCOMP] = !cz_q && (wpend_q || idx_q != 3'd0);
        end else if (stop_q ? idx_q != 3'd0 : wacc) begin
          // A stop pads the partial word with zero bytes before it goes out.
          wbuf  = {buf_q[WORD_BITS-9:0], stop_q ? 8'h00 : I_CH_WDATA};
          buf_d = wbuf;
          idx_d = idx_q + 3'd1;
          if (idx_q == LAST_IDX) begin
            chwr_d  = 1'b0;
            dout_d  = wbuf;
            par_d   = ~(^wbuf);
            wpend_d = 1'b1;
            idx_d   = '0;
            state_d = S_WR_WAIT;
          end
        end else if (stop_q) begin
          chwr_d  = 1'b0;
          dout_d  = '0;
          par_d   = 1'b1;
          state_d = S_WR_WAIT;
        end
      end
      S_WR_WAIT: begin
        if (eor_s || eof_s) begin
          done             = 1'b1;
          set_v[ST_DE]     = 1'b1;
          set_v[ST_CE]     = 1'b1;
          set_v[ST_UE]     = eof_s;
          set_v[ST_UC]     = !cz_q && wpend_q;
          set_v[ST_INCOMP] = !cz_q && wpend_q;
        end else if (wrdy_q && dem_s) begin
          wrdy_d  = 1'b0;
          tmr_d   = '0;
          wpend_d = 1'b0;
          set_v[ST_CE] = cz_q;
          if (cz_q || stop_q) begin
            dout_d = '0;
            par_d  = 1'b1;
          end else begin
            chwr_d  = 1'b1;
            state_d = S_WR_FILL;
          end
        end else if (!wrdy_q && !dem_s) begin
          wrdy_d = 1'b1;
          tmr_d  = '0;
          // Count zero waits until the padded or whole pending word has been taken.
          cz_d   = cz_q | (stop_q && !wpend_q);
        end
      end
      default: begin
        done = 1'b1;
      end
    endcase

    // ****************************************************************
    // Channel stop, interrupt, timeout and termination
    // ****************************************************************
    if (busy && I_WR && I_ADDR == ADDR_CMD && I_WDATA[CMD_STOP]) begin
      stop_d = 1'b1;
    end
    if (int_rise) begin
      set_v[ST_ATTN] = 1'b1;
      set_v[ST_DE]   = busy;
      set_v[ST_CE]   = busy;
    end
    if (kill && !int_rise) begin
      set_v[ST_TMO] = 1'b1;
      set_v[ST_UC]  = 1'b1;
    end
    if (done || kill) begin
      state_d = S_IDLE;
      rsel_d  = 1'b0;
      wsel_d  = 1'b0;
      rrdy_d  = 1'b0;
      wrdy_d  = 1'b0;
      cz_d    = 1'b0;
      buf_d   = '0;
      tmr_d   = '0;
      dout_d  = '0;
      par_d   = 1'b0;
      chrv_d  = 1'b0;
      chwr_d  = 1'b0;
      stop_d  = 1'b0;
      endp_d  = 1'b0;
      uep_d   = 1'b0;
      to_en_d = 1'b0;
      cmd_d   = CMD_IDLE;
    end

    // ****************************************************************
    // Register port
    // ****************************************************************
    // A hardware set in the same cycle as a software clear wins.
    stat_d = stat_q;
    if (I_WR && I_ADDR == ADDR_STAT) begin
      stat_d = stat_q & ~I_WDATA[8:1];
    end
    stat_d  = stat_d | set_v;
    rdata_d = '0;
    if (I_RD && I_ADDR == ADDR_CMD) begin
      rdata_d = {28'h0000000, stop_q, cmd_q};
    end else if (I_RD && I_ADDR == ADDR_STAT) begin
      rdata_d = {23'h000000, stat_q, busy};
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      state_q  <= S_IDLE;
      rsel_q   <= 1'b0;
      wsel_q   <= 1'b0;
      rrdy_q   <= 1'b0;
      wrdy_q   <= 1'b0;
      cz_q     <= 1'b0;
      par_q    <= 1'b0;
      dout_q   <= '0;
      buf_q    <= '0;
      idx_q    <= '0;
      cmd_q    <= CMD_IDLE;
      to_en_q  <= 1'b0;
      stop_q   <= 1'b0;
      endp_q   <= 1'b0;
      uep_q    <= 1'b0;
      wpend_q  <= 1'b0;
      int_d1_q <= 1'b0;
      tmr_q    <= '0;
      rdata_q  <= '0;
      chrv_q   <= 1'b0;
      chrd_q   <= '0;
      chwr_q   <= 1'b0;
      stat_q   <= STAT_RST;
    end else begin
      state_q  <= state_d;
      rsel_q   <= rsel_d;
      wsel_q   <= wsel_d;
      rrdy_q   <= rrdy_d;
      wrdy_q   <= wrdy_d;
      cz_q     <= cz_d;
      par_q    <= par_d;
      dout_q   <= dout_d;
      buf_q    <= buf_d;
      idx_q    <= idx_d;
      cmd_q    <= cmd_d;
      to_en_q  <= to_en_d;
      stop_q   <= stop_d;
      endp_q   <= endp_d;
      uep_q    <= uep_d;
      wpend_q  <= wpend_d;
      int_d1_q <= int_d1_d;
      tmr_q    <= tmr_d;
      rdata_q  <= rdata_d;
      chrv_q   <= chrv_d;
      chrd_q   <= chrd_d;
      chwr_q   <= chwr_d;
      stat_q   <= stat_d;
    end
  end

  assign O_RDATA      = rdata_q;
  assign O_CH_WREADY  = chwr_q;
  assign O_CH_RDATA   = chrd_q;
  assign O_CH_RVALID  = chrv_q;
  assign O_READ_SEL   = rsel_q;
  assign O_WRITE_SEL  = wsel_q;
  assign O_READ_RDY   = rrdy_q;
  assign O_WRITE_RDY  = wrdy_q;
  assign O_COUNT_ZERO = cz_q;
  assign O_DATA_OUT   = dout_q;
  assign O_PARITY_OUT = par_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  AST_RD_START: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    state_q == S_IDLE && I_WR && I_ADDR == ADDR_CMD && I_WDATA[2:0] == CMD_READ |=> rsel_q && rrdy_q)
    else $error("read command did not raise select and ready");
  AST_RRDY_DROP: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    rrdy_q && dem_s |=> !rrdy_q)
    else $error("read ready stayed up after demand");
  AST_RRDY_RISE: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    $rose(rrdy_q) |-> !$past(dem_s) && $past(buf_q) == '0)
    else $error("read ready rose with demand high or buffer loaded");
  AST_EOF_EXC: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    state_q == S_RD_WAIT && eof_s && !int_rise && !tmo |=> stat_q[ST_UE] && stat_q[ST_DE] && !rsel_q)
    else $error("file end did not set exception status");
  AST_CZ_RISE: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    $rose(cz_q) |-> (rrdy_q || wrdy_q) && !$past(dem_s))
    else $error("count zero rose without ready or with demand");
  AST_KILL: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    busy && int_rise |=> !rsel_q && !wsel_q && !rrdy_q && !wrdy_q && !cz_q && stat_q[ST_ATTN])
    else $error("interrupt did not end the operation");
  AST_TMO_RESTART: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    (rrdy_q || wrdy_q) && dem_s && !kill |=> tmr_q == 32'd0 ##1 tmr_q <= 32'd1)
    else $error("timeout not restarted by demand");
  AST_WRDY_DROP: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    wrdy_q && dem_s |=> !wrdy_q)
    else $error("write ready stayed up after demand");
  AST_PARITY: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    wrdy_q |-> ^{dout_q, par_q})
    else $error("output word parity is not odd");
  AST_WRDY_RISE: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    $rose(wrdy_q) |-> $stable(dout_q) && !$past(dem_s))
    else $error("write ready rose with moving data or demand high");
  AST_INCOMP: assert property (@(posedge I_CLK_SYS) disable iff (I_SYS_RST)
    state_q == S_WR_WAIT && (eor_s || eof_s) && wpend_q && !cz_q && !kill |=> stat_q[ST_INCOMP] && stat_q[ST_UC])
    else $error("early write end missed the incomplete check");

endmodule // pwh_word_adapter

// ==== testbench/pwh_dev_model.sv ====
// Behavioural model of the external device on the parallel word link.
// Assumes the bench pulses i_fire for one cycle to request one demand cycle.
`timescale 1ns/1ps
module pwh_dev_model
  import pwh_pkg::*;
#(
  parameter int WORD_BITS = WORD_BITS_DEF,
  parameter int HOLD_CYC  = 160
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_fire,
  input  wire logic [WORD_BITS-1:0] i_word,
  input  wire logic                 i_read_rdy,
  input  wire logic                 i_write_rdy,
  input  wire logic [WORD_BITS-1:0] i_data_out,
  output logic                      o_demand,
  output logic      [WORD_BITS-1:0] o_data,
  output logic                      o_parity,
  output logic      [WORD_BITS-1:0] o_seen,
  output logic                      o_busy
);
  int n;
  // ****************************************************************
  // Demand cycle
  // ****************************************************************
  initial begin
    o_demand = 1'h0;
    o_data   = '0;
    o_parity = 1'h0;
    o_seen   = '0;
    o_busy   = 1'h0;
    forever begin
      @(posedge i_clk);
      if (i_fire) begin
        o_busy <= 1'h1;
        for (n = 0; n < 2000 && !(i_read_rdy || i_write_rdy); n++) begin
          @(posedge i_clk);
        end
        o_data   <= i_word;
        o_parity <= ~^i_word;
        @(posedge i_clk);
        o_demand <= 1'h1;
        if (i_write_rdy) begin
          o_seen <= i_data_out;
        end
        repeat (HOLD_CYC) @(posedge i_clk);
        o_demand <= 1'h0;
        // Released lines show the inverse so a stale word is never mistaken for a fresh one.
        o_data   <= ~i_word;
        o_parity <= ~o_parity;
        o_busy   <= 1'h0;
      end
    end
  end
endmodule // pwh_dev_model

// ==== testbench/testbench.sv ====
// Self-checking bench for the parallel word handshake sequencer.
// Assumes the device model in pwh_dev_model and a 16-bit word.
`timescale 1ns/1ps
module testbench;
  import pwh_pkg::*;
  typedef struct packed {
    logic [15:0] word;
    logic [7:0]  b0;
    logic [7:0]  b1;
  } pwh_row_type;
  localparam pwh_row_type ROWS [4] = '{'{16'h1234, 8'h12, 8'h34}, '{16'ha5c3, 8'ha5, 8'hc3},
                                       '{16'hffff, 8'hff, 8'hff}, '{16'h0001, 8'h00, 8'h01}};
  localparam logic [31:0] ST_END = (32'h1 << ST_DE) | (32'h1 << ST_CE);
  localparam logic [31:0] ST_EXC = ST_END | (32'h1 << ST_UE);
  logic        I_CLK_SYS, I_SYS_RST, I_WR, I_RD, I_CH_WVALID, I_CH_RREADY;
  logic        I_END_RECORD, I_END_FILE, I_INTERRUPT, O_CH_WREADY, O_CH_RVALID;
  logic        O_READ_SEL, O_WRITE_SEL, O_READ_RDY, O_WRITE_RDY, O_COUNT_ZERO, O_PARITY_OUT;
  logic        dev_demand, dev_parity, dev_busy, dev_fire, wr_rdy_q;
  logic [7:0]  I_ADDR, I_CH_WDATA, O_CH_RDATA;
  logic [31:0] I_WDATA, O_RDATA, rd_val;
  logic [15:0] O_DATA_OUT, dev_data, dev_seen, dev_word;
  logic [7:0]  tx_q[$];
  logic [7:0]  rx_q[$];
  int          failures, check_count, late_cnt, max_late, i, n;

  pwh_word_adapter #(.TIMEOUT_CYC(32'd50)) pwh_word_adapter_i (
    .I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
    .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CH_WDATA(I_CH_WDATA), .I_CH_WVALID(I_CH_WVALID),
    .O_CH_WREADY(O_CH_WREADY), .O_CH_RDATA(O_CH_RDATA), .O_CH_RVALID(O_CH_RVALID),
    .I_CH_RREADY(I_CH_RREADY), .O_READ_SEL(O_READ_SEL), .O_WRITE_SEL(O_WRITE_SEL),
    .O_READ_RDY(O_READ_RDY), .O_WRITE_RDY(O_WRITE_RDY), .O_COUNT_ZERO(O_COUNT_ZERO),
    .O_DATA_OUT(O_DATA_OUT), .O_PARITY_OUT(O_PARITY_OUT), .I_DEMAND(dev_demand),
    .I_END_RECORD(I_END_RECORD), .I_END_FILE(I_END_FILE), .I_INTERRUPT(I_INTERRUPT),
    .I_DATA_IN(dev_data), .I_PARITY_IN(dev_parity));
  pwh_dev_model pwh_dev_model_i (
    .i_clk(I_CLK_SYS), .i_fire(dev_fire), .i_word(dev_word), .i_read_rdy(O_READ_RDY),
    .i_write_rdy(O_WRITE_RDY), .i_data_out(O_DATA_OUT), .o_demand(dev_demand), .o_data(dev_data),
    .o_parity(dev_parity), .o_seen(dev_seen), .o_busy(dev_busy));

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge I_CLK_SYS);
    I_ADDR  <= a;
    I_WDATA <= d;
    I_WR    <= 1'h1;
    @(posedge I_CLK_SYS);
    I_WR    <= 1'h0;
  endtask
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge I_CLK_SYS);
    I_ADDR <= a;
    I_RD   <= 1'h1;
    @(posedge I_CLK_SYS);
    I_RD   <= 1'h0;
    #1;
    d = O_RDATA;
  endtask
  // Reads the sticky status, compares it and clears it for the next scenario.
  task automatic stat_is(input logic [31:0] exp);
    reg_rd(ADDR_STAT, rd_val);
    chk(rd_val, exp);
    reg_wr(ADDR_STAT, 32'h000001fe);
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge I_CLK_SYS);
    #1;
  endtask
  task automatic wait_rdy;
    for (n = 0; n < 2000 && !(O_READ_RDY || O_WRITE_RDY); n++) cyc(1);
  endtask
  task automatic fire(input logic [15:0] w);
    @(posedge I_CLK_SYS);
    dev_word <= w;
    dev_fire <= 1'h1;
    @(posedge I_CLK_SYS);
    dev_fire <= 1'h0;
    cyc(1);
    for (n = 0; n < 3000 && dev_busy; n++) cyc(1);
  endtask
  // Called only while demand is low.
  task automatic end_sig(input logic rec, input logic fil);
    @(posedge I_CLK_SYS);
    I_END_RECORD <= rec;
    I_END_FILE   <= fil;
    repeat (200) @(posedge I_CLK_SYS);
    I_END_RECORD <= 1'h0;
    I_END_FILE   <= 1'h0;
    cyc(20);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ****************************************************************
  // Clock, channel side and monitors
  // ****************************************************************
  initial begin
    I_CLK_SYS = 1'h0;
    forever #2.5 I_CLK_SYS = ~I_CLK_SYS;
  end
  always @(posedge I_CLK_SYS) begin
    I_CH_RREADY <= ~I_CH_RREADY;
    if (O_CH_RVALID && I_CH_RREADY) rx_q.push_back(O_CH_RDATA);
    if (I_CH_WVALID && O_CH_WREADY) void'(tx_q.pop_front());
    I_CH_WVALID <= (tx_q.size() > 0);
    I_CH_WDATA  <= (tx_q.size() > 0) ? tx_q[0] : 8'h00;
    if (dev_demand && (O_READ_RDY || O_WRITE_RDY)) late_cnt <= late_cnt + 1;
    else late_cnt <= 0;
    if (late_cnt > max_late) max_late <= late_cnt;
    if (O_WRITE_RDY) chk(O_PARITY_OUT, ~^O_DATA_OUT);
    if (O_WRITE_RDY && !wr_rdy_q) chk(dev_demand, 1'h0);
    wr_rdy_q <= O_WRITE_RDY;
  end
  initial begin
    repeat (30000) @(posedge I_CLK_SYS);
    failures++;
    tally_and_finish();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {I_SYS_RST, I_WR, I_RD, I_CH_WVALID, I_CH_RREADY, dev_fire} = 6'h20;
    {I_END_RECORD, I_END_FILE, I_INTERRUPT, wr_rdy_q} = 4'h0;
    {I_ADDR, I_WDATA, I_CH_WDATA, dev_word} = '0;
    {failures, check_count, late_cnt, max_late} = '0;
    repeat (10) @(posedge I_CLK_SYS);
    I_SYS_RST <= 1'h0;
    cyc(1);
    chk({O_READ_SEL, O_WRITE_SEL, O_READ_RDY, O_WRITE_RDY, O_COUNT_ZERO, O_CH_WREADY}, 32'h0);
    reg_rd(8'h10, rd_val);
    chk(rd_val, 32'h0);
    reg_wr(ADDR_CMD, {29'h0, CMD_READ});
    cyc(1);
    chk({O_READ_SEL, O_READ_RDY}, 32'h3);
    for (i = 0; i < 4; i++) begin
      fire(ROWS[i].word);
      for (n = 0; n < 500 && rx_q.size() < 2; n++) cyc(1);
      chk({rx_q[0], rx_q[1]}, {ROWS[i].b0, ROWS[i].b1});
      rx_q.delete();
    end
    end_sig(1'h1, 1'h1);
    chk(O_READ_SEL, 1'h0);
    stat_is(ST_EXC);
    reg_wr(ADDR_CMD, {29'h0, CMD_WRITE});
    cyc(1);
    chk({O_WRITE_SEL, O_CH_WREADY}, 32'h3);
    for (i = 0; i < 4; i++) begin
      tx_q.push_back(ROWS[i].b0);
      tx_q.push_back(ROWS[i].b1);
      fire(16'h0000);
      chk(dev_seen, ROWS[i].word);
    end
    tx_q.push_back(8'h00);
    tx_q.push_back(8'hff);
    wait_rdy();
    end_sig(1'h0, 1'h1);
    stat_is(ST_EXC | (32'h1 << ST_UC) | (32'h1 << ST_INCOMP));
    reg_wr(ADDR_CMD, {29'h0, CMD_READ});
    wait_rdy();
    reg_wr(ADDR_CMD, 32'h00000008);
    cyc(3);
    chk({O_COUNT_ZERO, O_READ_RDY, dev_demand}, 32'h6);
    reg_rd(ADDR_CMD, rd_val);
    chk(rd_val, 32'h9);
    fire(16'hbeef);
    wait_rdy();
    chk({O_READ_RDY, 8'(rx_q.size())}, 32'h100);
    end_sig(1'h1, 1'h0);
    stat_is(ST_END);
    reg_wr(ADDR_CMD, {29'h0, CMD_WRITE});
    tx_q.push_back(8'ha5);
    cyc(10);
    reg_wr(ADDR_CMD, 32'h00000008);
    wait_rdy();
    chk({O_COUNT_ZERO, O_WRITE_RDY}, 32'h1);
    fire(16'h0000);
    chk(dev_seen, 16'ha500);
    wait_rdy();
    chk({O_COUNT_ZERO, O_WRITE_RDY, O_DATA_OUT}, 32'h30000);
    fire(16'h0000);
    wait_rdy();
    chk({O_COUNT_ZERO, dev_seen}, 32'h10000);
    end_sig(1'h1, 1'h0);
    stat_is(ST_END);
    reg_wr(ADDR_CMD, {29'h0, CMD_READ});
    wait_rdy();
    @(posedge I_CLK_SYS);
    I_INTERRUPT <= 1'h1;
    cyc(10);
    chk({O_READ_SEL, O_READ_RDY, O_COUNT_ZERO}, 32'h0);
    cyc(190);
    I_INTERRUPT <= 1'h0;
    stat_is(ST_END | (32'h1 << ST_ATTN));
    @(posedge I_CLK_SYS);
    I_INTERRUPT <= 1'h1;
    cyc(200);
    I_INTERRUPT <= 1'h0;
    stat_is(32'h1 << ST_ATTN);
    reg_wr(ADDR_CMD, {29'h0, CMD_READ_T});
    cyc(30);
    chk({O_READ_SEL, O_READ_RDY}, 32'h3);
    cyc(70);
    chk({O_READ_SEL, O_READ_RDY}, 32'h0);
    stat_is((32'h1 << ST_TMO) | (32'h1 << ST_UC));
    reg_wr(ADDR_CMD, {29'h0, CMD_WRIT_T});
    cyc(5);
    I_SYS_RST <= 1'h1;
    cyc(3);
    chk({O_WRITE_SEL, O_WRITE_RDY, O_CH_WREADY}, 32'h0);
    @(posedge I_CLK_SYS);
    I_SYS_RST <= 1'h0;
    cyc(5);
    chk({24'h0, max_late > RDY_DROP_CYC}, 32'h0);
    tally_and_finish();
  end
endmodule // testbench
